/* File: core/rbc_regs.sv */
// control and status register bank with clock check engine
// Behaviour
// - enabled status changes are captured and held
// - clear bits drop captures only during write
// - bit 10 picks crystal or external reference
// - pending bit is OR of masked requests
// - serial status read shows lock, valid, enables
// - status and line registers: length B, addresses 0,1
// - limits and period: addresses 2-4, length 18
// - antenna register: address 5, length C
// - host bus reads of line, limit, period and antenna registers return last write
// - termination bits enable buffer termination
// - direction bits turn buffers to drive
// - swap bit picks receive source buffer
// - port choice picks rear or front buffers
// - force bit holds attention while set
// - period counter ends, compares counts, restarts
// - valid only strictly between both limits
// - valid holds until next period ends
// - count registers double buffered with status
// - antenna direction bits set buffer drive
// - antenna outputs load together in one cycle
// - monitor alarms sticky, write one clears
// - master enable gates every request
module rbc_regs (
  input wire logic mclk, // 100 MHz clock
  input wire logic rst_n, // async reset
  input wire logic ce, // clock enable
  input wire rbc_pkg::rbc_pcie_req_s pcie_req, // host bus request
  output logic [31:0] pcie_rdata, // host bus read data
  output logic pcie_rvalid, // read data pulse
  input wire rbc_pkg::rbc_spi_req_s spi_req, // local serial request
  output logic [23:0] spi_rdata, // local serial read data
  output logic spi_rvalid, // read data pulse
  input wire logic master_int_enable, // board master interrupt enable
  input wire logic receiver_osc_unlocked_n, // receiver lock, low locked
  input wire logic calsource_osc_unlocked_n, // cal source lock, low locked
  input wire logic xtal_ref_in, // onboard crystal reference
  input wire logic ext_ref_in, // external received reference
  input wire logic [3:0] monitor_alarm_n, // tcrit1, tcrit0, alarm1, alarm0
  input wire logic rear_rx_line, // rear receive buffer data in
  input wire logic rear_tx_line, // rear transmit buffer data in
  input wire logic front_rx_line, // front receive buffer data in
  input wire logic front_tx_line, // front transmit buffer data in
  input wire logic host_tx, // host serial data out
  output logic host_rx, // host serial data in
  output logic [3:0] buf_drive, // rear rx, rear tx, front rx, front tx
  output logic [2:0] coax_ref_out, // bezel reference outputs
  output rbc_pkg::rbc_line_s line_ctl, // buffer direction and termination
  output rbc_pkg::rbc_ant_s ant_ctl, // antenna outputs
  output logic monitor_reset_o, // monitor reset level
  output logic monitor_reset_oe, // monitor reset drive enable
  output logic attention // attention to host
);
  import rbc_pkg::*;

  logic [10:0] ctl_reg;
  rbc_line_s line_reg;
  rbc_ant_s ant_reg;
  logic [6:0] mon_reg;
  logic [RBC_CNT_W-1:0] low_reg, high_reg, period_reg, tick_reg;
  logic [RBC_CNT_W-1:0] cnt_e_reg, cnt_t_reg, cap_e_reg, cap_t_reg;
  logic ok_e_reg, ok_t_reg, ext_d_reg, xtal_d_reg;
  logic [3:0] cos_flag_reg, cos_prev_reg, alarm_reg;
  logic attention_reg, host_rx_reg;
  logic [3:0] buf_drive_reg;
  logic [2:0] coax_reg;
  logic [31:0] pcie_rdata_reg;
  logic pcie_rvalid_reg, spi_rvalid_reg;
  logic [23:0] spi_rdata_reg;
  logic w_en;
  logic [11:0] w_off;
  logic [31:0] w_data;
  logic terminal, e_edge, t_edge, attn_src;
  logic [3:0] cos_src, cos_set, cos_clr, alarm_clr;

  // local serial address to bus offset
  function automatic logic [11:0] spi_off(input logic [2:0] a);
    unique case (a)
      RBC_SPI_STATUS: spi_off = RBC_OFF_STATUS;
      RBC_SPI_LINE: spi_off = RBC_OFF_LINE;
      RBC_SPI_LOW: spi_off = RBC_OFF_LOW;
      RBC_SPI_HIGH: spi_off = RBC_OFF_HIGH;
      RBC_SPI_PERIOD: spi_off = RBC_OFF_PERIOD;
      RBC_SPI_ANT: spi_off = RBC_OFF_ANT;
      RBC_SPI_MON: spi_off = RBC_OFF_MON;
      default: spi_off = 12'hFFF;
    endcase
  endfunction

  // local serial transfer mask per address
  function automatic logic [23:0] spi_mask(input logic [2:0] a);
    unique case (a)
      RBC_SPI_STATUS: spi_mask = 24'((32'h1 << RBC_LEN_STATUS) - 1);
      RBC_SPI_LINE: spi_mask = 24'((32'h1 << RBC_LEN_LINE) - 1);
      RBC_SPI_LOW, RBC_SPI_HIGH, RBC_SPI_PERIOD:
        spi_mask = 24'((32'h1 << RBC_LEN_LIMIT) - 1);
      RBC_SPI_ANT: spi_mask = 24'((32'h1 << RBC_LEN_ANT) - 1);
      RBC_SPI_MON: spi_mask = 24'((32'h1 << RBC_LEN_MON) - 1);
      default: spi_mask = 24'h000000;
    endcase
  endfunction

  // one write per cycle, host bus first
  always_comb begin
    w_en = 1'b0;
    w_off = 12'h000;
    w_data = 32'h00000000;
    if (pcie_req.wr) begin
      w_en = 1'b1;
      w_off = pcie_req.addr;
      w_data = pcie_req.wdata;
    end else if (spi_req.wr) begin
      w_en = 1'b1;
      w_off = spi_off(spi_req.addr);
      w_data = {8'h00, spi_req.wdata & spi_mask(spi_req.addr)};
    end
  end

  // change of state and alarm event terms
  always_comb begin
    cos_src = {receiver_osc_unlocked_n, calsource_osc_unlocked_n, ok_e_reg, ok_t_reg};
    cos_set = (cos_src ^ cos_prev_reg) & ctl_reg[3:0];
    cos_clr = 4'h0;
    alarm_clr = 4'h0;
    if (w_en && w_off == RBC_OFF_STATUS) begin
      cos_clr = w_data[RBC_B_CLR_LO +: 4];
    end
    if (w_en && w_off == RBC_OFF_MON) begin
      alarm_clr = w_data[RBC_B_ALARM_LO +: 4];
    end
    attn_src = (|cos_flag_reg) | (|(alarm_reg & mon_reg[3:0]))
      | line_reg.force_attention;
  end

  // writable control registers
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ctl_reg <= RBC_RST_CTL;
      line_reg <= rbc_line_s'(RBC_RST_CTL);
      ant_reg <= rbc_ant_s'(12'h000);
      mon_reg <= RBC_RST_MON;
      low_reg <= RBC_RST_CNT;
      high_reg <= RBC_RST_CNT;
      period_reg <= RBC_RST_CNT;
    end else if (ce && w_en) begin
      unique case (w_off)
        RBC_OFF_STATUS: ctl_reg <= {w_data[10:8], 4'h0, w_data[3:0]};
        RBC_OFF_LINE: line_reg <= rbc_line_s'(w_data[10:0]);
        RBC_OFF_LOW: low_reg <= w_data[23:0];
        RBC_OFF_HIGH: high_reg <= w_data[23:0];
        RBC_OFF_PERIOD: period_reg <= w_data[23:0];
        RBC_OFF_ANT: ant_reg <= rbc_ant_s'(w_data[11:0]);
        RBC_OFF_MON: mon_reg <= w_data[6:0];
        default: ;
      endcase
    end
  end

  // change of state capture, set wins over clear
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cos_prev_reg <= 4'h0;
      cos_flag_reg <= 4'h0;
    end else if (ce) begin
      cos_prev_reg <= cos_src;
      cos_flag_reg <= (cos_flag_reg & ~cos_clr) | cos_set;
    end
  end

  // monitor alarm capture, set wins over clear
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      alarm_reg <= 4'h0;
    end else if (ce) begin
      alarm_reg <= (alarm_reg & ~alarm_clr) | ~monitor_alarm_n;
    end
  end

  // reference edge detection and period end
  assign e_edge = ext_ref_in & ~ext_d_reg;
  assign t_edge = xtal_ref_in & ~xtal_d_reg;
  assign terminal = (tick_reg >= period_reg);

  // clock check engine
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ext_d_reg <= 1'b0;
      xtal_d_reg <= 1'b0;
      tick_reg <= RBC_RST_CNT;
      cnt_e_reg <= RBC_RST_CNT;
      cnt_t_reg <= RBC_RST_CNT;
      cap_e_reg <= RBC_RST_CNT;
      cap_t_reg <= RBC_RST_CNT;
      ok_e_reg <= 1'b0;
      ok_t_reg <= 1'b0;
    end else if (ce) begin
      ext_d_reg <= ext_ref_in;
      xtal_d_reg <= xtal_ref_in;
      if (terminal) begin
        tick_reg <= RBC_RST_CNT;
        cnt_e_reg <= {{(RBC_CNT_W-1){1'b0}}, e_edge};
        cnt_t_reg <= {{(RBC_CNT_W-1){1'b0}}, t_edge};
        cap_e_reg <= cnt_e_reg;
        cap_t_reg <= cnt_t_reg;
        ok_e_reg <= (cnt_e_reg > low_reg) && (cnt_e_reg < high_reg);
        ok_t_reg <= (cnt_t_reg > low_reg) && (cnt_t_reg < high_reg);
      end else begin
        tick_reg <= tick_reg + 24'h000001;
        cnt_e_reg <= cnt_e_reg + {23'h000000, e_edge};
        cnt_t_reg <= cnt_t_reg + {23'h000000, t_edge};
      end
    end
  end

  // attention, reference and serial path outputs
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      attention_reg <= 1'b0;
      coax_reg <= 3'h0;
      host_rx_reg <= 1'b1;
      buf_drive_reg <= 4'h0;
    end else if (ce) begin
      attention_reg <= master_int_enable & attn_src;
      coax_reg <= {3{ctl_reg[RBC_B_REF_SEL] ? ext_ref_in : xtal_ref_in}};
      unique case ({line_reg.front_rear_port_choice, line_reg.receive_path_swap})
        2'b00: host_rx_reg <= rear_rx_line;
        2'b01: host_rx_reg <= rear_tx_line;
        2'b10: host_rx_reg <= front_rx_line;
        2'b11: host_rx_reg <= front_tx_line;
      endcase
      // transmit on the position not used for receive
      buf_drive_reg <= 4'h0;
      unique case ({line_reg.front_rear_port_choice, line_reg.receive_path_swap})
        2'b00: buf_drive_reg[1] <= host_tx;
        2'b01: buf_drive_reg[0] <= host_tx;
        2'b10: buf_drive_reg[3] <= host_tx;
        2'b11: buf_drive_reg[2] <= host_tx;
      endcase
    end
  end

  // host bus read, data one cycle after request
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pcie_rdata_reg <= 32'h00000000;
      pcie_rvalid_reg <= 1'b0;
    end else if (ce) begin
      pcie_rvalid_reg <= pcie_req.rd;
      if (pcie_req.rd) begin
        unique case (pcie_req.addr)
          RBC_OFF_STATUS: pcie_rdata_reg <= {master_int_enable & attn_src,
            20'h00000, ctl_reg};
          RBC_OFF_LINE: pcie_rdata_reg <= {21'h000000, line_reg};
          RBC_OFF_LOW: pcie_rdata_reg <= {8'h00, low_reg};
          RBC_OFF_HIGH: pcie_rdata_reg <= {8'h00, high_reg};
          RBC_OFF_PERIOD: pcie_rdata_reg <= {8'h00, period_reg};
          RBC_OFF_CNT_EXT: pcie_rdata_reg <= {7'h00, ok_e_reg, cap_e_reg};
          RBC_OFF_CNT_XTAL: pcie_rdata_reg <= {7'h00, ok_t_reg, cap_t_reg};
          RBC_OFF_ANT: pcie_rdata_reg <= {20'h00000, ant_reg};
          RBC_OFF_MON: pcie_rdata_reg <= {20'h00000, alarm_reg, 1'b0, mon_reg};
          default: pcie_rdata_reg <= 32'h00000000;
        endcase
      end
    end
  end

  // local serial read, masked to the transfer length
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      spi_rdata_reg <= 24'h000000;
      spi_rvalid_reg <= 1'b0;
    end else if (ce) begin
      spi_rvalid_reg <= spi_req.rd;
      if (spi_req.rd) begin
        unique case (spi_req.addr)
          RBC_SPI_STATUS: spi_rdata_reg <= {13'h0000, ctl_reg[10:8],
            receiver_osc_unlocked_n, calsource_osc_unlocked_n,
            ok_e_reg, ok_t_reg, ctl_reg[3:0]};
          RBC_SPI_LINE: spi_rdata_reg <= {13'h0000, line_reg};
          RBC_SPI_LOW: spi_rdata_reg <= low_reg;
          RBC_SPI_HIGH: spi_rdata_reg <= high_reg;
          RBC_SPI_PERIOD: spi_rdata_reg <= period_reg;
          RBC_SPI_ANT: spi_rdata_reg <= {12'h000, ant_reg};
          RBC_SPI_MON: spi_rdata_reg <= {12'h000, alarm_reg, 1'b0, mon_reg};
          default: spi_rdata_reg <= 24'h000000;
        endcase
      end
    end
  end

  // outputs straight from flops, monitor reset level tied low
  assign pcie_rdata = pcie_rdata_reg;
  assign pcie_rvalid = pcie_rvalid_reg;
  assign spi_rdata = spi_rdata_reg;
  assign spi_rvalid = spi_rvalid_reg;
  assign host_rx = host_rx_reg;
  assign buf_drive = buf_drive_reg;
  assign coax_ref_out = coax_reg;
  assign line_ctl = line_reg;
  assign ant_ctl = ant_reg;
  assign monitor_reset_o = 1'b0;
  assign monitor_reset_oe = mon_reg[RBC_B_MON_RESET];
  assign attention = attention_reg;

  // checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  AST_COS_CAPTURE: assert property (
    ce && cos_set != 4'h0 |=> (cos_flag_reg & $past(cos_set)) == $past(cos_set))
    else $error("enabled change not captured");
  AST_COS_CLEAR: assert property (
    ce && (cos_clr & ~cos_set) != 4'h0
      |=> (cos_flag_reg & $past(cos_clr & ~cos_set)) == 4'h0
      && ctl_reg[RBC_B_CLR_LO +: 4] == 4'h0)
    else $error("change flag not cleared or clear stored");
  // the reset release edge is skipped: outputs are still held at zero there
  AST_REF_SELECT: assert property (
    rst_n && ce |=> coax_ref_out == {3{$past(ctl_reg[RBC_B_REF_SEL]) ? $past(ext_ref_in)
      : $past(xtal_ref_in)}})
    else $error("wrong reference on coax outputs");
  AST_PENDING: assert property (
    ce && pcie_req.rd && pcie_req.addr == RBC_OFF_STATUS
      |=> pcie_rvalid && pcie_rdata[RBC_B_PENDING] == $past(master_int_enable & attn_src))
    else $error("pending bit mismatch");
  AST_SPI_STATUS_LEN: assert property (
    ce && spi_req.rd && spi_req.addr == RBC_SPI_STATUS |=> spi_rdata[23:11] == 13'h0000)
    else $error("status serial read exceeds length");
  AST_PERIOD_WRITE: assert property (
    ce && pcie_req.wr && pcie_req.addr == RBC_OFF_PERIOD
      |=> period_reg == $past(pcie_req.wdata[23:0]))
    else $error("period write not stored");
  AST_RX_PATH: assert property (
    ce && !line_reg.front_rear_port_choice && line_reg.receive_path_swap
      |=> host_rx == $past(rear_tx_line))
    else $error("receive path swap wrong");
  AST_TX_PATH: assert property (
    rst_n && ce && !line_reg.front_rear_port_choice && !line_reg.receive_path_swap
      |=> buf_drive == {2'b00, $past(host_tx), 1'b0})
    else $error("transmit not on rear transmit buffer");
  AST_FORCE: assert property (
    ce && line_reg.force_attention && master_int_enable |=> attention)
    else $error("force bit did not raise attention");
  AST_CAPTURE: assert property (
    ce && terminal |=> cap_e_reg == $past(cnt_e_reg) && tick_reg == RBC_RST_CNT)
    else $error("count not captured at period end");
  AST_WINDOW: assert property (
    ce && terminal |=> ok_t_reg == ($past(cnt_t_reg) > $past(low_reg)
      && $past(cnt_t_reg) < $past(high_reg)))
    else $error("valid window compare wrong");
  AST_HOLD: assert property (
    ce && !terminal |=> $stable(ok_e_reg) && $stable(ok_t_reg) && $stable(cap_e_reg))
    else $error("status changed inside a period");
  AST_ANT_LOAD: assert property (
    ce && w_en && w_off == RBC_OFF_ANT |=> ant_ctl == $past(w_data[11:0]))
    else $error("antenna outputs not loaded together");
  AST_ALARM_CLEAR: assert property (
    ce && alarm_clr[0] && monitor_alarm_n[0] |=> !alarm_reg[0])
    else $error("alarm not cleared by write one");
  AST_MON_RESET: assert property (
    ce && w_en && w_off == RBC_OFF_MON
      |=> monitor_reset_oe == $past(w_data[RBC_B_MON_RESET]) && !monitor_reset_o)
    else $error("monitor reset drive wrong");
  AST_MASTER: assert property (
    ce && !master_int_enable |=> !attention)
    else $error("attention while master enable low");

  COV_COS_EVENT: cover property (ce && cos_set != 4'h0 ##1 attention);
  COV_PERIOD_OK: cover property (ce && terminal ##1 ok_e_reg && ok_t_reg);
  COV_ALARM: cover property (ce && alarm_reg[3] && mon_reg[3] ##1 attention);
  COV_CLEAR: cover property (ce && cos_clr != 4'h0 ##1 cos_flag_reg == 4'h0);
  COV_SPI_WRITE: cover property (ce && spi_req.wr && !pcie_req.wr
    && spi_req.addr == RBC_SPI_ANT);
endmodule // rbc_regs

/* File: common/rbc_pkg.sv */
// shared constants, layouts and carriers for the receiver board register bank
package rbc_pkg;
  // register byte offsets on the host bus
  localparam logic [11:0] RBC_OFF_STATUS = 12'h008;
  localparam logic [11:0] RBC_OFF_LINE = 12'h00C;
  localparam logic [11:0] RBC_OFF_LOW = 12'h010;
  localparam logic [11:0] RBC_OFF_HIGH = 12'h014;
  localparam logic [11:0] RBC_OFF_PERIOD = 12'h018;
  localparam logic [11:0] RBC_OFF_CNT_EXT = 12'h01C;
  localparam logic [11:0] RBC_OFF_CNT_XTAL = 12'h020;
  localparam logic [11:0] RBC_OFF_ANT = 12'h024;
  localparam logic [11:0] RBC_OFF_MON = 12'h028;
  // local serial port addresses
  localparam logic [2:0] RBC_SPI_STATUS = 3'h0;
  localparam logic [2:0] RBC_SPI_LINE = 3'h1;
  localparam logic [2:0] RBC_SPI_LOW = 3'h2;
  localparam logic [2:0] RBC_SPI_HIGH = 3'h3;
  localparam logic [2:0] RBC_SPI_PERIOD = 3'h4;
  localparam logic [2:0] RBC_SPI_ANT = 3'h5;
  localparam logic [2:0] RBC_SPI_MON = 3'h6;
  // local serial transfer lengths in bits
  localparam int RBC_LEN_STATUS = 'hB;
  localparam int RBC_LEN_LINE = 'hB;
  localparam int RBC_LEN_LIMIT = 'h18;
  localparam int RBC_LEN_ANT = 'hC;
  localparam int RBC_LEN_MON = 'hC;
  // field positions
  localparam int RBC_B_PENDING = 31;
  localparam int RBC_B_REF_SEL = 10;
  localparam int RBC_B_CLR_LO = 4;
  localparam int RBC_B_ALARM_LO = 8;
  localparam int RBC_B_MON_RESET = 6;
  localparam int RBC_B_CNT_OK = 24;
  localparam int RBC_CNT_W = 24;
  // values after reset
  localparam logic [10:0] RBC_RST_CTL = 11'h000;
  localparam logic [23:0] RBC_RST_CNT = 24'h000000;
  localparam logic [6:0] RBC_RST_MON = 7'h00;

  // line buffer control, bit 10 down to bit 0
  typedef struct packed {
    logic force_attention;
    logic front_rear_port_choice;
    logic receive_path_swap;
    logic rear_receive_buffer_direction;
    logic rear_transmit_buffer_direction;
    logic front_receive_buffer_direction;
    logic front_transmit_buffer_direction;
    logic rear_receive_buffer_termination;
    logic rear_transmit_buffer_termination;
    logic front_receive_buffer_termination;
    logic front_transmit_buffer_termination;
  } rbc_line_s;

  // antenna control, bit 11 down to bit 0
  typedef struct packed {
    logic [3:0] ant_data;
    logic [3:0] ant_dir;
    logic [2:0] spare;
    logic cal_switch;
  } rbc_ant_s;

  // host bus request
  typedef struct packed {
    logic wr;
    logic rd;
    logic [11:0] addr;
    logic [31:0] wdata;
  } rbc_pcie_req_s;

  // local serial port request, already deframed
  typedef struct packed {
    logic wr;
    logic rd;
    logic [2:0] addr;
    logic [23:0] wdata;
  } rbc_spi_req_s;
endpackage

/* File: verif/rbc_host_model.sv */
// host side model driving the host bus and the local serial port
module rbc_host_model (
  input wire logic mclk, // 100 MHz clock
  output rbc_pkg::rbc_pcie_req_s pcie_req, // host bus request
  input wire logic [31:0] pcie_rdata, // host read data
  input wire logic pcie_rvalid, // host read pulse
  output rbc_pkg::rbc_spi_req_s spi_req, // serial request
  input wire logic [23:0] spi_rdata, // serial read data
  input wire logic spi_rvalid // serial read pulse
);
  timeunit 1ns;
  timeprecision 1ps;
  import rbc_pkg::*;
  // both ports idle from time zero
  initial begin
    pcie_req = '0;
    spi_req = '0;
  end
  // host bus access: strobe for one taken edge, then watch four edges
  task automatic pacc(input logic w, input logic [11:0] a, input logic [31:0] d,
    output logic [31:0] q);
    q = 'x;
    pcie_req <= '{wr: w, rd: ~w, addr: a, wdata: d};
    @(posedge mclk);
    pcie_req <= '0;
    repeat (4) begin
      @(posedge mclk);
      if (!w && pcie_rvalid === 1'b1) q = pcie_rdata;
    end
  endtask
  // serial access, same shape; a missing answer leaves unknown data
  task automatic sacc(input logic w, input logic [2:0] a, input logic [23:0] d,
    output logic [23:0] q);
    q = 'x;
    spi_req <= '{wr: w, rd: ~w, addr: a, wdata: d};
    @(posedge mclk);
    spi_req <= '0;
    repeat (4) begin
      @(posedge mclk);
      if (!w && spi_rvalid === 1'b1) q = spi_rdata;
    end
  endtask
endmodule // rbc_host_model

/* File: verif/test_rbc_regs.sv */
// self-checking bench for the receiver board register bank
module test_rbc_regs;
  timeunit 1ns;
  timeprecision 1ps;
  import rbc_pkg::*;
  // read-write registers: host offset, serial address, width mask
  localparam logic [11:0] off_tab [5] = '{RBC_OFF_LINE, RBC_OFF_LOW, RBC_OFF_HIGH,
    RBC_OFF_PERIOD, RBC_OFF_ANT};
  localparam logic [2:0] sad_tab [5] = '{RBC_SPI_LINE, RBC_SPI_LOW, RBC_SPI_HIGH,
    RBC_SPI_PERIOD, RBC_SPI_ANT};
  localparam logic [31:0] msk_tab [5] = '{32'h7FF, 32'hFFFFFF, 32'hFFFFFF,
    32'hFFFFFF, 32'hFFF};
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic mie = 1'b0;
  logic ce = 1'b1;
  logic rx_n = 1'b1, cal_n = 1'b1, xr = 1'b1, er = 1'b0, htx = 1'b0;
  logic ref_run = 1'b0;
  logic [3:0] alarm_n = 4'hF;
  logic [3:0] lines = 4'h0;
  rbc_pcie_req_s preq;
  rbc_spi_req_s sreq;
  logic [31:0] prd, q, r, d;
  logic [23:0] srd, sq;
  logic prv, srv, hrx, attn, mro, mroe;
  logic [3:0] bdrv;
  logic [2:0] coax;
  logic [1:0] st;
  rbc_line_s lctl;
  rbc_ant_s actl;
  int failures = 0;
  int cmp_count = 0;
  int ra = 0, rb = 0, j, cx, c, lo, hi;

  rbc_regs u_rbc_regs (
    .mclk(mclk), .rst_n(rst_n), .ce(ce), .pcie_req(preq), .pcie_rdata(prd),
    .pcie_rvalid(prv), .spi_req(sreq), .spi_rdata(srd), .spi_rvalid(srv),
    .master_int_enable(mie), .receiver_osc_unlocked_n(rx_n),
    .calsource_osc_unlocked_n(cal_n), .xtal_ref_in(xr), .ext_ref_in(er),
    .monitor_alarm_n(alarm_n), .rear_rx_line(lines[0]), .rear_tx_line(lines[1]),
    .front_rx_line(lines[2]), .front_tx_line(lines[3]), .host_tx(htx),
    .host_rx(hrx), .buf_drive(bdrv), .coax_ref_out(coax), .line_ctl(lctl),
    .ant_ctl(actl), .monitor_reset_o(mro), .monitor_reset_oe(mroe), .attention(attn));

  rbc_host_model u_rbc_host_model (
    .mclk(mclk), .pcie_req(preq), .pcie_rdata(prd), .pcie_rvalid(prv),
    .spi_req(sreq), .spi_rdata(srd), .spi_rvalid(srv));

  // 100 MHz clock
  always #5 mclk = ~mclk;
  // references: crystal every 10 cycles, external every 8
  always @(posedge mclk) begin
    if (ref_run) begin
      ra = (ra + 1) % 10;
      rb = (rb + 1) % 8;
      xr <= (ra < 5);
      er <= (rb < 4);
    end
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      failures++;
      $display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  task automatic pw(input logic [11:0] a, input logic [31:0] v);
    u_rbc_host_model.pacc(1'b1, a, v, q);
  endtask
  task automatic pr(input logic [11:0] a);
    u_rbc_host_model.pacc(1'b0, a, 32'h0, q);
  endtask
  task automatic conclude;
    if (failures == 0 && cmp_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  // watchdog well beyond the expected run of about 2200 cycles
  initial begin
    #200us;
    failures++;
    conclude();
  end

  initial begin
    cx = $urandom(69);
    repeat (12) @(posedge mclk);
    rst_n <= 1'b1;
    @(posedge mclk);
    // reset state of every register and of the receive, line, antenna and monitor reset outputs
    for (int i = 0; i < 9; i++) begin
      pr(RBC_OFF_STATUS + 12'(4 * i));
      chk(q, 32'h0);
    end
    chk({hrx, lctl, actl, mroe, mro}, {lines[0], 25'h0});
    // random writes on alternating ports, read back on both
    for (int k = 0; k < 15; k++) begin
      j = k % 5;
      r = $urandom;
      d = r & msk_tab[j];
      if (k % 2) pw(off_tab[j], d);
      else u_rbc_host_model.sacc(1'b1, sad_tab[j], r[23:0], sq);
      pr(off_tab[j]);
      chk(q, d);
      u_rbc_host_model.sacc(1'b0, sad_tab[j], 24'h0, sq);
      chk(sq, d[23:0]);
      if (j == 0) begin
        chk(lctl, d);
        lines <= 4'($urandom);
        htx <= 1'($urandom);
        repeat (2) @(posedge mclk);
        chk(hrx, lines[d[9:8]]);
        chk(bdrv, 32'(htx) << {d[9], ~d[8]});
      end
      if (j == 4) chk(actl, d);
    end
    // reference source select with crystal held 1, external 0
    u_rbc_host_model.sacc(1'b1, RBC_SPI_STATUS, 24'h400, sq);
    pr(RBC_OFF_STATUS);
    chk(q & 32'h40F, 32'h400);
    chk(coax, 3'b000);
    pw(RBC_OFF_STATUS, 32'h0);
    chk(coax, 3'b111);
    // clock check: 200-cycle period gives crystal 20, external 25
    ref_run <= 1'b1;
    lo = 15;
    hi = 22;
    pw(RBC_OFF_LINE, 32'h0);
    pw(RBC_OFF_LOW, 32'(lo));
    pw(RBC_OFF_HIGH, 32'(hi));
    pw(RBC_OFF_PERIOD, 32'd199);
    for (int i = 0; i < 4; i++) begin
      repeat (420) @(posedge mclk);
      for (int m = 0; m < 2; m++) begin
        pr(m ? RBC_OFF_CNT_XTAL : RBC_OFF_CNT_EXT);
        c = q[23:0];
        st[m] = q[24];
        chk(c inside {[(m ? 19 : 24):(m ? 21 : 26)]}, 1'b1);
        chk(q[24], c > lo && c < hi);
        d = q;
        pr(m ? RBC_OFF_CNT_XTAL : RBC_OFF_CNT_EXT);
        chk(q, d);
      end
      if (i == 0) begin
        cx = c;
        u_rbc_host_model.sacc(1'b0, RBC_SPI_STATUS, 24'h0, sq);
        chk(sq, {16'h0, rx_n, cal_n, st[0], st[1], 4'h0});
      end
      lo = cx - (i == 0 ? 0 : i == 1 ? 1 : 5);
      hi = cx + (i == 0 ? 5 : i == 1 ? 1 : 0);
      pw(RBC_OFF_LOW, 32'(lo));
      pw(RBC_OFF_HIGH, 32'(hi));
    end
    // change capture, clear, masking by master enable
    mie <= 1'b1;
    pw(RBC_OFF_STATUS, 32'h00C);
    rx_n <= 1'b0;
    repeat (4) @(posedge mclk);
    chk(attn, 1'b1);
    pr(RBC_OFF_STATUS);
    chk(q[31], 1'b1);
    pw(RBC_OFF_STATUS, 32'h08C);
    chk(attn, 1'b0);
    cal_n <= 1'b0;
    repeat (4) @(posedge mclk);
    chk(attn, 1'b1);
    mie <= 1'b0;
    pr(RBC_OFF_STATUS);
    chk({q[31], attn}, 2'b00);
    mie <= 1'b1;
    pw(RBC_OFF_STATUS, 32'h04C);
    chk(attn, 1'b0);
    // forced attention
    pw(RBC_OFF_LINE, 32'h400);
    chk(attn, 1'b1);
    pw(RBC_OFF_LINE, 32'h0);
    chk(attn, 1'b0);
    // monitor alarm sticky, enabled, write one clears
    pw(RBC_OFF_MON, 32'h041);
    chk({mroe, mro}, 2'b10);
    alarm_n <= 4'hE;
    repeat (3) @(posedge mclk);
    alarm_n <= 4'hF;
    repeat (3) @(posedge mclk);
    chk(attn, 1'b1);
    pr(RBC_OFF_MON);
    chk(q & 32'hFFF, 32'h141);
    pw(RBC_OFF_MON, 32'h141);
    pr(RBC_OFF_MON);
    chk(q & 32'hFFF, 32'h041);
    chk(attn, 1'b0);
    // read-only counts ignore writes, unmapped places read 0
    pr(RBC_OFF_CNT_EXT);
    d = q;
    pw(RBC_OFF_CNT_EXT, 32'hFFFFFFFF);
    pr(RBC_OFF_CNT_EXT);
    chk(q, d);
    pr(12'h02C);
    chk(q, 32'h0);
    u_rbc_host_model.sacc(1'b0, 3'h7, 24'h0, sq);
    chk(sq, 24'h0);
    // clock enable low: a write in that time must not land
    ce <= 1'b0;
    pw(RBC_OFF_LOW, 32'h00005A);
    ce <= 1'b1;
    pr(RBC_OFF_LOW);
    chk(q, 32'(lo));
    conclude();
  end
endmodule // test_rbc_regs
